// [ctbc_pkg.sv]
package ctbc_pkg;

    // ==========================================
    // operation codes
    localparam logic [3:0] OP_BIT_TEST = 4'h0;
    localparam logic [3:0] OP_JUMP_ABSOLUTE = 4'h1;
    localparam logic [3:0] OP_CALL = 4'h2;
    localparam logic [3:0] OP_ZERO_DESTINATION = 4'h3;
    localparam logic [3:0] OP_ZERO_CARRY_FLAG = 4'h4;
    localparam logic [3:0] OP_ZERO_NEGATIVE_FLAG = 4'h5;
    localparam logic [3:0] OP_ZERO_ZERO_FLAG = 4'h6;
    localparam logic [3:0] OP_COMPARE_SUBTRACT = 4'h7;
    localparam logic [3:0] OP_DECIMAL_CARRY_ADD = 4'h8;

    // ==========================================
    // flag word layout, stack step, reset word and width constants
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 8;
    localparam logic [15:0] MASK_CARRY = 16'h0001;
    localparam logic [15:0] MASK_ZERO = 16'h0002;
    localparam logic [15:0] MASK_NEGATIVE = 16'h0004;
    localparam logic [15:0] STACK_STEP = 16'h0002;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam int WORD_MSB = 15;
    localparam int BYTE_MSB = 7;
    localparam int DIGITS = 4;

    // ==========================================
    // carriers
    typedef struct packed {
        logic [3:0] op;
        logic byte_mode;
        logic [15:0] src;
        logic [15:0] dst;
        logic [15:0] next_pc;
    } ctbc_req_t;

    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] sp;
        logic [15:0] flags;
    } ctbc_arch_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [15:0] data;
        logic byte_mode;
    } ctbc_write_t;

endpackage : ctbc_pkg

// [ctbc_exec.sv]
`timescale 1ns/100ps
// What this block does
// RL1 - bit test ANDs operands for flags only, writes nothing
// RL2 - bit test: zero if AND result zero, carry if nonzero, overflow cleared
// RL3 - single-bit mask makes carry equal the tested bit level
// RL4 - absolute jump loads source word into program counter, flags untouched
// RL5 - absolute jump is a word copy of any source operand to counter
// RL6 - call: latch target, stack pointer minus 2, push counter, load target
// RL7 - pushed value is the address of the instruction after the call
// RL8 - call reaches full 64K space, word only, flags unchanged
// RL9 - clear writes zero to destination, word or byte, flags unchanged
// RL10 - clear-carry resets only carry via mask-clear of constant 1
// RL11 - clear-negative ANDs flag word with FFFB, only negative reset
// RL12 - clear-zero ANDs flag word with FFFD, only zero reset
// RL13 - compare adds inverted source plus one to destination
// RL14 - compare discards difference, operands untouched, only flags change
// RL15 - compare sets negative, zero, carry out of MSB and overflow
// RL16 - decimal add-carry adds carry flag to destination in BCD
// RL17 - decimal carry on 9999 or 99 wrap, zero, negative from MSB
// RL18 - mode bits of the flag word are never altered
// RL19 - word treated as four positive BCD digits; non-BCD undefined
// RL20 - byte forms use low eight bits, flags from bit 7
module ctbc_exec (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clk_en,
    // request
    input wire logic req_valid,
    input wire ctbc_pkg::ctbc_req_t req,
    // architectural state
    output ctbc_pkg::ctbc_arch_t arch_q,
    // destination / stack write
    output ctbc_pkg::ctbc_write_t wr_q,
    // status
    output logic busy_q,
    output logic done_q
);

    // ==========================================
    // call sequencing
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PUSH = 3'b010,
        ST_LOAD = 3'b100
    } ctbc_state_t;

    ctbc_state_t state_q, state_d;
    logic [15:0] tmp_q, tmp_d;
    ctbc_pkg::ctbc_arch_t arch_d;
    ctbc_pkg::ctbc_write_t wr_d;
    logic busy_d, done_d;

    // ==========================================
    // combinational results
    logic [15:0] and_res, sub_res, bcd_res, opd_src, opd_dst;
    logic [16:0] sub_sum;
    logic sub_c, sub_v, bcd_c;
    logic [4:0] dig_carry;

    assign opd_src = req.byte_mode ? {8'h00, req.src[7:0]} : req.src;          // see RL20
    assign opd_dst = req.byte_mode ? {8'h00, req.dst[7:0]} : req.dst;          // see RL20
    assign and_res = opd_src & opd_dst;                                        // see RL1
    assign sub_sum = {1'b0, opd_dst} + {1'b0, ~opd_src} + 17'h00001;           // see RL13
    assign sub_res = sub_sum[15:0];

    always_comb begin
        if (req.byte_mode) begin
            // upper byte of the inverted source is all ones, so bit 8 holds the inverted byte carry
            sub_c = ~sub_res[8];                                               // see RL20
            sub_v = (opd_dst[7] != opd_src[7]) && (sub_res[7] != opd_dst[7]);  // see RL15
        end else begin
            sub_c = sub_sum[16];                                               // see RL15
            sub_v = (opd_dst[15] != opd_src[15]) && (sub_res[15] != opd_dst[15]);
        end
    end

    // decimal adder: immediate zero source, carry flag as carry in
    genvar g;
    assign dig_carry[0] = arch_q.flags[ctbc_pkg::FLAG_C];                      // see RL16
    generate
        for (g = 0; g < ctbc_pkg::DIGITS; g++) begin : g_bcd
            logic [4:0] raw;
            assign raw = {1'b0, opd_dst[4*g+3:4*g]} + {4'h0, dig_carry[g]};    // see RL19
            assign dig_carry[g+1] = (raw > 5'h09);
            assign bcd_res[4*g+3:4*g] = dig_carry[g+1] ? 4'((raw + 5'h06) & 5'h0F) : raw[3:0];
        end
    endgenerate
    assign bcd_c = req.byte_mode ? dig_carry[2] : dig_carry[ctbc_pkg::DIGITS]; // see RL17

    // ==========================================
    // next state
    always_comb begin
        logic [15:0] res;
        logic res_msb;
        res = '0;
        res_msb = 1'b0;
        state_d = state_q;
        tmp_d = tmp_q;
        arch_d = arch_q;
        wr_d = '0;
        busy_d = busy_q;
        done_d = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                if (req_valid) begin
                    arch_d.pc = req.next_pc;
                    unique case (req.op)
                        ctbc_pkg::OP_BIT_TEST: begin
                            res = req.byte_mode ? {8'h00, and_res[7:0]} : and_res;
                            res_msb = req.byte_mode ? res[ctbc_pkg::BYTE_MSB] : res[ctbc_pkg::WORD_MSB];
                            arch_d.flags[ctbc_pkg::FLAG_N] = res_msb;
                            arch_d.flags[ctbc_pkg::FLAG_Z] = (res == 16'h0000);   // see RL2
                            arch_d.flags[ctbc_pkg::FLAG_C] = (res != 16'h0000);   // see RL2, RL3
                            arch_d.flags[ctbc_pkg::FLAG_V] = 1'b0;                // see RL2
                            done_d = 1'b1;
                        end
                        ctbc_pkg::OP_JUMP_ABSOLUTE: begin
                            arch_d.pc = req.src;                                  // see RL4, RL5
                            done_d = 1'b1;
                        end
                        ctbc_pkg::OP_CALL: begin
                            tmp_d = req.src;                                      // see RL6
                            arch_d.sp = arch_q.sp - ctbc_pkg::STACK_STEP;         // see RL6
                            state_d = ST_PUSH;
                            busy_d = 1'b1;
                        end
                        ctbc_pkg::OP_ZERO_DESTINATION: begin
                            wr_d.valid = 1'b1;                                    // see RL9
                            wr_d.addr = req.dst;
                            wr_d.data = ctbc_pkg::RESET_WORD;
                            wr_d.byte_mode = req.byte_mode;
                            done_d = 1'b1;
                        end
                        ctbc_pkg::OP_ZERO_CARRY_FLAG: begin
                            arch_d.flags = arch_q.flags & ~ctbc_pkg::MASK_CARRY;  // see RL10, RL18
                            done_d = 1'b1;
                        end
                        ctbc_pkg::OP_ZERO_NEGATIVE_FLAG: begin
                            arch_d.flags = arch_q.flags & ~ctbc_pkg::MASK_NEGATIVE; // see RL11
                            done_d = 1'b1;
                        end
                        ctbc_pkg::OP_ZERO_ZERO_FLAG: begin
                            arch_d.flags = arch_q.flags & ~ctbc_pkg::MASK_ZERO;   // see RL12
                            done_d = 1'b1;
                        end
                        ctbc_pkg::OP_COMPARE_SUBTRACT: begin
                            // difference goes nowhere but the flags
                            res = req.byte_mode ? {8'h00, sub_res[7:0]} : sub_res; // see RL14
                            res_msb = req.byte_mode ? res[ctbc_pkg::BYTE_MSB] : res[ctbc_pkg::WORD_MSB];
                            arch_d.flags[ctbc_pkg::FLAG_N] = res_msb;             // see RL15
                            arch_d.flags[ctbc_pkg::FLAG_Z] = (res == 16'h0000);
                            arch_d.flags[ctbc_pkg::FLAG_C] = sub_c;
                            arch_d.flags[ctbc_pkg::FLAG_V] = sub_v;
                            done_d = 1'b1;
                        end
                        ctbc_pkg::OP_DECIMAL_CARRY_ADD: begin
                            res = req.byte_mode ? {8'h00, bcd_res[7:0]} : bcd_res; // see RL16
                            res_msb = req.byte_mode ? res[ctbc_pkg::BYTE_MSB] : res[ctbc_pkg::WORD_MSB];
                            wr_d.valid = 1'b1;
                            wr_d.addr = req.dst;
                            wr_d.data = res;
                            wr_d.byte_mode = req.byte_mode;
                            arch_d.flags[ctbc_pkg::FLAG_N] = res_msb;             // see RL17
                            arch_d.flags[ctbc_pkg::FLAG_Z] = (res == 16'h0000);
                            arch_d.flags[ctbc_pkg::FLAG_C] = bcd_c;
                            // overflow undefined; left as it was
                            done_d = 1'b1;
                        end
                        default: begin
                            // unknown codes retire with only the counter advanced
                            done_d = 1'b1;
                        end
                    endcase
                end
            end
            ST_PUSH: begin
                wr_d.valid = 1'b1;                                                // see RL6
                wr_d.addr = arch_q.sp;
                wr_d.data = arch_q.pc;                                            // see RL7
                wr_d.byte_mode = 1'b0;                                            // see RL8
                state_d = ST_LOAD;
            end
            ST_LOAD: begin
                arch_d.pc = tmp_q;                                                // see RL6, RL8
                state_d = ST_IDLE;
                busy_d = 1'b0;
                done_d = 1'b1;
            end
            default: begin
                state_d = ST_IDLE;
                busy_d = 1'b0;
            end
        endcase
    end

    // ==========================================
    // registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            tmp_q <= ctbc_pkg::RESET_WORD;
            arch_q <= '0;
            wr_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            tmp_q <= tmp_d;
            arch_q <= arch_d;
            wr_q <= wr_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

endmodule : ctbc_exec

// [ctbc_checker.sv]
`timescale 1ns/100ps
// ==========================================
// port checker
module ctbc_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clk_en,
    // request
    input wire logic req_valid,
    input wire ctbc_pkg::ctbc_req_t req,
    // state, write and status
    input wire ctbc_pkg::ctbc_arch_t arch_q,
    input wire ctbc_pkg::ctbc_write_t wr_q,
    input wire logic busy_q,
    input wire logic done_q
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    wire logic tk = clk_en && req_valid && !busy_q;
    sequence s_call_take;
        tk && req.op == ctbc_pkg::OP_CALL;
    endsequence
    sequence s_call_run;
        busy_q ##1 wr_q.valid ##1 (done_q && !busy_q);
    endsequence
    a_call_steps: assert property (s_call_take |=> s_call_run)
        else $error("call sequence out of step");
    a_call_push: assert property (s_call_take |-> ##2 (wr_q.data == $past(req.next_pc, 2)
        && wr_q.addr == $past(arch_q.sp, 2) - 16'h0002)) else $error("call push wrong");
    a_call_target: assert property (s_call_take |-> ##3 (arch_q.pc == $past(req.src, 3)
        && $stable(arch_q.flags))) else $error("call target wrong");
    a_op_retire: assert property (tk && req.op != ctbc_pkg::OP_CALL |=> done_q && !busy_q)
        else $error("op did not retire");
    a_jump_load: assert property (tk && req.op == ctbc_pkg::OP_JUMP_ABSOLUTE |=>
        arch_q.pc == $past(req.src) && $stable(arch_q.flags) && !wr_q.valid) else $error("jump wrong");
    a_mode_hold: assert property ($stable({arch_q.flags[15:9], arch_q.flags[7:3]}))
        else $error("mode bits changed");
    a_carry_clear: assert property (tk && req.op == ctbc_pkg::OP_ZERO_CARRY_FLAG |=>
        arch_q.flags == ($past(arch_q.flags) & 16'hFFFE)) else $error("carry clear wrong");
    a_neg_clear: assert property (tk && req.op == ctbc_pkg::OP_ZERO_NEGATIVE_FLAG |=>
        arch_q.flags == ($past(arch_q.flags) & 16'hFFFB)) else $error("negative clear wrong");
    a_zero_clear: assert property (tk && req.op == ctbc_pkg::OP_ZERO_ZERO_FLAG |=>
        arch_q.flags == ($past(arch_q.flags) & 16'hFFFD)) else $error("zero clear wrong");
    a_bit_flags: assert property (tk && req.op == ctbc_pkg::OP_BIT_TEST |=> !wr_q.valid
        && !arch_q.flags[ctbc_pkg::FLAG_V] && arch_q.flags[ctbc_pkg::FLAG_C] != arch_q.flags[ctbc_pkg::FLAG_Z]
        && arch_q.flags[ctbc_pkg::FLAG_Z] == ($past(req.byte_mode) ? $past(req.src[7:0] & req.dst[7:0]) == 8'h00
        : $past(req.src & req.dst) == 16'h0000)) else $error("bit test flags wrong");
    a_cmp_nowrite: assert property (tk && req.op == ctbc_pkg::OP_COMPARE_SUBTRACT |=> !wr_q.valid)
        else $error("compare wrote a result");
    a_clear_write: assert property (tk && req.op == ctbc_pkg::OP_ZERO_DESTINATION |=> wr_q.valid
        && wr_q.data == 16'h0000 && $stable(arch_q.flags)) else $error("clear wrong");
endmodule : ctbc_checker

// [ctbc_tb.sv]
`timescale 1ns/100ps
module tb;
    logic mclk;
    logic resetn;
    logic clk_en;
    logic req_valid;
    ctbc_pkg::ctbc_req_t req;
    ctbc_pkg::ctbc_arch_t arch_q;
    ctbc_pkg::ctbc_write_t wr_q;
    logic busy_q;
    logic done_q;
    int errors;
    int n_compared;
    logic [15:0] e_pc, e_sp, e_fl;
    ctbc_exec uut (.mclk(mclk), .resetn(resetn), .clk_en(clk_en), .req_valid(req_valid), .req(req),
        .arch_q(arch_q), .wr_q(wr_q), .busy_q(busy_q), .done_q(done_q));
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    function automatic logic [15:0] nzcv(logic [15:0] f, logic [15:0] r, logic bm, logic c, logic v);
        f[ctbc_pkg::FLAG_N] = bm ? r[7] : r[15];
        f[ctbc_pkg::FLAG_Z] = bm ? (r[7:0] == 8'h00) : (r == 16'h0000);
        f[ctbc_pkg::FLAG_C] = c;
        f[ctbc_pkg::FLAG_V] = v;
        return f;
    endfunction : nzcv
    // value+carry as bcd digits; top bit of the result is the decimal carry out
    function automatic logic [16:0] bcd(logic [15:0] d, logic c, logic bm);
        int v;
        int n;
        logic [16:0] r;
        n = bm ? 2 : 4;
        v = 0;
        r = 17'h00000;
        for (int k = n - 1; k >= 0; k--) v = v * 10 + int'(d[4*k +: 4]);
        v = v + int'(c);
        r[16] = (v == (bm ? 100 : 10000));
        for (int k = 0; k < n; k++) begin
            r[4*k +: 4] = 4'(v % 10);
            v = v / 10;
        end
        return r;
    endfunction : bcd
    task automatic run(logic [3:0] op, logic bm, logic [15:0] s, logic [15:0] d);
        logic [16:0] r;
        logic [15:0] npc;
        logic [15:0] wd;
        ctbc_pkg::ctbc_write_t w;
        int m;
        npc = 16'($urandom);
        wd = 16'h0000;
        w = '0;
        m = bm ? 7 : 15;
        e_pc = (op == ctbc_pkg::OP_JUMP_ABSOLUTE) ? s : npc;
        case (op)
            ctbc_pkg::OP_BIT_TEST: begin
                e_fl = nzcv(e_fl, s & d, bm, 1'b0, 1'b0);
                e_fl[ctbc_pkg::FLAG_C] = !e_fl[ctbc_pkg::FLAG_Z];
            end
            ctbc_pkg::OP_CALL: begin
                e_sp = e_sp - 16'h0002;
                e_pc = s;
                wd = npc;
            end
            ctbc_pkg::OP_ZERO_CARRY_FLAG: e_fl = e_fl & 16'hFFFE;
            ctbc_pkg::OP_ZERO_NEGATIVE_FLAG: e_fl = e_fl & 16'hFFFB;
            ctbc_pkg::OP_ZERO_ZERO_FLAG: e_fl = e_fl & 16'hFFFD;
            ctbc_pkg::OP_COMPARE_SUBTRACT: begin
                r = bm ? 17'({1'b0, d[7:0]} + {1'b0, ~s[7:0]} + 9'h001) : {1'b0, d} + {1'b0, ~s} + 17'h00001;
                e_fl = nzcv(e_fl, r[15:0], bm, bm ? r[8] : r[16], d[m] != s[m] && r[m] != d[m]);
            end
            ctbc_pkg::OP_DECIMAL_CARRY_ADD: begin
                r = bcd(d, e_fl[ctbc_pkg::FLAG_C], bm);
                wd = r[15:0];
                e_fl = nzcv(e_fl, r[15:0], bm, r[16], e_fl[ctbc_pkg::FLAG_V]);
            end
            default: ;
        endcase
        @(posedge mclk);
        req_valid <= 1'b1;
        req <= '{op: op, byte_mode: bm, src: s, dst: d, next_pc: npc};
        @(posedge mclk);
        req_valid <= 1'b0;
        #1;
        if (wr_q.valid) w = wr_q;
        for (int k = 0; k < 8 && !done_q; k++) begin
            @(posedge mclk);
            #1;
            if (wr_q.valid) w = wr_q;
        end
        check("done", 16'h0001, {15'h0000, done_q});
        check("pc", e_pc, arch_q.pc);
        check("sp", e_sp, arch_q.sp);
        check("flags", e_fl, arch_q.flags);
        if (op == ctbc_pkg::OP_CALL || op == ctbc_pkg::OP_ZERO_DESTINATION || op == ctbc_pkg::OP_DECIMAL_CARRY_ADD) begin
            check("wr addr", op == ctbc_pkg::OP_CALL ? e_sp : d, w.addr);
            check("wr data", wd & (bm ? 16'h00FF : 16'hFFFF), w.data & (bm ? 16'h00FF : 16'hFFFF));
            check("wr byte", {15'h0000, bm}, {15'h0000, w.byte_mode});
        end else begin
            check("wr valid", 16'h0000, {15'h0000, w.valid});
        end
    endtask : run
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // a few hundred ops of under ten cycles each; this leaves wide margin
    initial begin
        #200000;
        errors++;
        summarize();
    end
    initial begin
        logic [3:0] op;
        logic [15:0] d;
        resetn = 1'b0;
        clk_en = 1'b1;
        req_valid = 1'b0;
        req = '0;
        {e_pc, e_sp, e_fl} = 48'h000000000000;
        errors = 0;
        n_compared = 0;
        d = 16'($urandom(32'h5db1));
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        check("reset state", 16'h0000, arch_q.pc | arch_q.sp | arch_q.flags);
        run(ctbc_pkg::OP_BIT_TEST, 1'b1, 16'h0100, 16'h0100);
        run(ctbc_pkg::OP_BIT_TEST, 1'b1, 16'h0008, 16'h0008);
        run(ctbc_pkg::OP_DECIMAL_CARRY_ADD, 1'b0, 16'h0000, 16'h9999);
        run(ctbc_pkg::OP_DECIMAL_CARRY_ADD, 1'b1, 16'h0000, 16'h1299);
        run(ctbc_pkg::OP_COMPARE_SUBTRACT, 1'b0, 16'h8000, 16'h7FFF);
        run(ctbc_pkg::OP_COMPARE_SUBTRACT, 1'b1, 16'h0001, 16'hFF80);
        run(ctbc_pkg::OP_CALL, 1'b0, 16'hFFFE, 16'h1234);
        // enable low: a pending jump must be ignored and nothing may move
        @(posedge mclk);
        clk_en <= 1'b0;
        req_valid <= 1'b1;
        req <= '{op: ctbc_pkg::OP_JUMP_ABSOLUTE, byte_mode: 1'b0, src: 16'h5A5A, dst: 16'h0000, next_pc: 16'h0000};
        repeat (3) @(posedge mclk);
        #1;
        check("frozen pc", e_pc, arch_q.pc);
        check("frozen done", 16'h0000, {15'h0000, done_q});
        @(posedge mclk);
        req_valid <= 1'b0;
        clk_en <= 1'b1;
        $display("test directed done");
        for (int i = 0; i < 300; i++) begin
            op = 4'($urandom % 9);
            for (int k = 0; k < 4; k++) d[4*k +: 4] = 4'($urandom % 10);
            if (op != ctbc_pkg::OP_DECIMAL_CARRY_ADD) d = 16'($urandom);
            run(op, 1'($urandom) & (op == 0 || op == 3 || op == 7 || op == 8), 16'($urandom), d);
        end
        $display("test random done");
        summarize();
    end
endmodule : tb
bind ctbc_exec ctbc_checker chk (.mclk(mclk), .resetn(resetn), .clk_en(clk_en), .req_valid(req_valid),
    .req(req), .arch_q(arch_q), .wr_q(wr_q), .busy_q(busy_q), .done_q(done_q));
